// *** core/line_signaling_io_consts.svh ***
`ifndef LINE_SIGNALING_IO_CONSTS_SVH
`define LINE_SIGNALING_IO_CONSTS_SVH

// Global command numbers
`define LSI_G_IRQ_CLEAR   5'h02
`define LSI_G_CHOPPER     5'h08
`define LSI_G_DEB_HOOK    5'h09
`define LSI_G_DEB_GKEY    5'h0A
`define LSI_G_BIDIR1      5'h0B
`define LSI_G_BIDIR2      5'h0C
`define LSI_G_DIR1        5'h0D
`define LSI_G_DIR2        5'h0E
`define LSI_G_RING_TRIP   5'h0F
// Local command numbers
`define LSI_L_IRQ_EN      5'h02
`define LSI_L_DEB_TIMES   5'h04
`define LSI_L_SIGNAL      5'h09

// Field positions
`define LSI_RT_ENABLE     7
`define LSI_RT_ISEL       6
`define LSI_RT_OSEL_LSB   3
`define LSI_RT_IPOL       2
`define LSI_RT_OPOL       1
`define LSI_IE_LSB        4
`define LSI_DSH_LSB       4
`define LSI_GK_LSB        0
`define LSI_CHOP_FAST_LSB 4
`define LSI_SIG_HOOK      7
`define LSI_SIG_GKEY      6
`define LSI_SIG_B1        5
`define LSI_SIG_B2        4
`define LSI_SIG_PEND      3
`define LSI_CI_B2         4
`define LSI_CI_B1         3

// Reset values
`define LSI_RST_BYTE      8'h00
`define LSI_RST_CHOPPER   8'h00

// Timing, frame sync at 125 us
`define LSI_FRAME_US      125
`define LSI_SAMPLE_US     250
`define LSI_TICK_MS       2
`define LSI_GK_STEP_MS    12
`define LSI_SAMPLE_FRAMES (`LSI_SAMPLE_US / `LSI_FRAME_US)
`define LSI_TICK_FRAMES   (`LSI_TICK_MS * 1000 / `LSI_FRAME_US)
`define LSI_MS_FRAMES     (1000 / `LSI_FRAME_US)
`define LSI_GK_FRAMES     (`LSI_GK_STEP_MS * 1000 / `LSI_FRAME_US)
`define LSI_GK_MAX        3'd6
`define LSI_SLOW_MAX_CODE 4'hD

// Fast chopper half periods at the 25 MHz system clock
`define LSI_SYS_HZ        25000000
`define LSI_FAST0_HZ      256000
`define LSI_FAST1_HZ      512000
`define LSI_FAST2_HZ      16384000
`define LSI_HALF(f)       (((`LSI_SYS_HZ / (2 * (f))) < 1) ? 1 : (`LSI_SYS_HZ / (2 * (f))))

`endif

// *** core/line_signaling_io_pkg.sv ***
package line_signaling_io_pkg;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       global_cmd;
    logic [4:0] index;
    logic [2:0] channel;
    logic [7:0] data;
  } cmd_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cmd_rsp_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] channel;
    logic [7:0] data;
  } ci_octet_s;

  typedef enum logic [2:0] {
    TRIP_OUT_ONE   = 3'h0,
    TRIP_OUT_TWO   = 3'h1,
    TRIP_OUT_THREE = 3'h2,
    TRIP_BIDIR_ONE = 3'h3,
    TRIP_BIDIR_TWO = 3'h4
  } trip_out_e;

endpackage

// *** core/line_signaling_io.sv ***
// Functional notes
// - Each of eight channels: two inputs, two bidirectional pins, three outputs.
// - Two global reads return debounced first and second inputs, one bit per channel.
// - Host mode: inputs readable in local register; C/I mode: in upstream octet.
// - Two direction registers, bit per channel, 0 input, 1 output, reset input.
// - Input bidir pins read via global registers; host mode writes outputs there only.
// - C/I mode: bidir outputs driven from downstream octet; pin one reported upstream.
// - Host mode writes outputs through local register; reads return last written bits.
// - C/I mode: the three outputs are written only from the downstream octet.
// - Ring trip enable; select bit picks input; three-bit field picks ring output.
// - Valid off-hook immediately sets selected ring output to idle, overriding stored value.
// - Input polarity bit: 0 means off-hook active low, 1 active high.
// - Output polarity 1: idle low, ring high; 0: idle high, ring low. The bit is stored as written; only bit 0 of the register is always stored as 0.
// - Change on debounced inputs or input bidir pins raises a channel source.
// - Four enable bits per channel, one per source; disabled sources ignored.
// - Local register read clears channel sources; global clear clears all channels.
// - Two chopper clocks: slow 2 to 28 ms, fast selectable among three rates.
// - Hook filter samples every 250 us; change restarts 2 ms counter, terminal 0..30.
// - Debounced hook bit updates only when the counter reaches its programmed value.
// - Ground-key filter: up/down counter 0..6, sampled every 250 us (code 0) or 12..180 ms.
// - Counter at 6 sets latch, at 0 clears it, otherwise latch holds.
// - Both filters time from frame sync; without it debounced bits freeze.
`include "line_signaling_io_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module line_signaling_io (
  input  wire logic                         sys_clk,
  input  wire logic                         rst_n,
  input  wire logic                         gci_mode,
  input  wire logic                         frame_sync,
  input  wire line_signaling_io_pkg::cmd_req_s  cmd,
  output var  line_signaling_io_pkg::cmd_rsp_s  rsp,
  input  wire line_signaling_io_pkg::ci_octet_s ci_down,
  output logic [7:0][7:0]                   ci_up,
  input  wire logic [7:0]                   hook_input,
  input  wire logic [7:0]                   groundkey_input,
  input  wire logic [7:0]                   bidir_pin_one_in,
  output logic [7:0]                        bidir_pin_one_out,
  output logic [7:0]                        bidir_pin_one_oe,
  input  wire logic [7:0]                   bidir_pin_two_in,
  output logic [7:0]                        bidir_pin_two_out,
  output logic [7:0]                        bidir_pin_two_oe,
  output logic [7:0]                        line_output_one,
  output logic [7:0]                        line_output_two,
  output logic [7:0]                        line_output_three,
  output logic [7:0]                        channel_irq,
  output logic                              slow_chopper_out,
  output logic                              fast_chopper_out
);

  logic       rst_meta;
  logic       rst_sync;
  logic       fs_q;
  logic       fs_edge;
  logic [6:0] frame_cnt;
  logic       sample_tick;
  logic       tick_2ms;
  logic       tick_1ms;
  logic       tick_gk;
  logic [6:0] gk_frames;
  logic [3:0] ms_frames;
  logic [3:0] tick_frames;
  logic       half_frames;

  logic [7:0]      debounced_hook_bit;
  logic [7:0]      debounced_groundkey_bit;
  logic [7:0]      bidir1_data_all;
  logic [7:0]      bidir2_data_all;
  logic [7:0]      bidir1_direction;
  logic [7:0]      bidir2_direction;
  logic [7:0]      ring_trip_config;
  logic [7:0]      chopper_config;
  logic [7:0][3:0] source_irq_enables;
  logic [7:0][7:0] channel_debounce_times;
  logic [7:0][2:0] line_out_reg;
  logic [7:0][3:0] pending;
  logic [7:0]      trip_hold;

  logic            ring_trip_enable;
  logic            trip_input_select;
  logic [2:0]      trip_output_select;
  logic            trip_input_polarity;
  logic            trip_output_polarity;

  logic            host_wr;
  logic            host_rd;
  logic            ci_wr;
  logic [7:0]      cmd_ch_dec;
  logic [7:0]      ci_ch_dec;
  logic            irq_clear_all;
  logic [7:0]      local_sig_read;
  logic [7:0]      sw_output_write;

  assign ring_trip_enable     = ring_trip_config[`LSI_RT_ENABLE];
  assign trip_input_select    = ring_trip_config[`LSI_RT_ISEL];
  assign trip_output_select   = ring_trip_config[`LSI_RT_OSEL_LSB +: 3];
  assign trip_input_polarity  = ring_trip_config[`LSI_RT_IPOL];
  assign trip_output_polarity = ring_trip_config[`LSI_RT_OPOL];

  assign host_wr       = cmd.valid & cmd.write;
  assign host_rd       = cmd.valid & ~cmd.write;
  assign ci_wr         = ci_down.valid & gci_mode;
  assign cmd_ch_dec    = 8'h01 << cmd.channel;
  assign ci_ch_dec     = 8'h01 << ci_down.channel;
  assign irq_clear_all = host_wr & cmd.global_cmd & (cmd.index == `LSI_G_IRQ_CLEAR);
  assign local_sig_read  = (host_rd & ~cmd.global_cmd & (cmd.index == `LSI_L_SIGNAL)) ? cmd_ch_dec : 8'h00;
  assign sw_output_write = (host_wr & ~gci_mode & ~cmd.global_cmd & (cmd.index == `LSI_L_SIGNAL))
                           ? cmd_ch_dec : (ci_wr ? ci_ch_dec : 8'h00);

  // Reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Frame-sync derived timebase; no frame sync, no ticks
  assign fs_edge     = frame_sync & ~fs_q;
  assign half_frames = 1'(`LSI_SAMPLE_FRAMES - 1);
  assign ms_frames   = 4'(`LSI_MS_FRAMES - 1);
  assign tick_frames = 4'(`LSI_TICK_FRAMES - 1);
  assign gk_frames   = 7'(`LSI_GK_FRAMES - 1);

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      fs_q        <= 1'b0;
      frame_cnt   <= 7'h00;
      sample_tick <= 1'b0;
      tick_1ms    <= 1'b0;
      tick_2ms    <= 1'b0;
      tick_gk     <= 1'b0;
    end else begin
      fs_q        <= frame_sync;
      sample_tick <= fs_edge & (frame_cnt[0] == half_frames);
      tick_1ms    <= fs_edge & (frame_cnt[2:0] == ms_frames[2:0]);
      tick_2ms    <= fs_edge & (frame_cnt[3:0] == tick_frames);
      tick_gk     <= fs_edge & (frame_cnt == gk_frames);
      if (fs_edge) begin
        frame_cnt <= (frame_cnt == gk_frames) ? 7'h00 : frame_cnt + 7'h01;
      end
    end
  end

  // Host command registers
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      bidir1_direction <= `LSI_RST_BYTE;
      bidir2_direction <= `LSI_RST_BYTE;
      ring_trip_config <= `LSI_RST_BYTE;
      chopper_config   <= `LSI_RST_CHOPPER;
      bidir1_data_all  <= `LSI_RST_BYTE;
      bidir2_data_all  <= `LSI_RST_BYTE;
    end else begin
      if (host_wr & cmd.global_cmd) begin
        if (cmd.index == `LSI_G_DIR1) begin
          bidir1_direction <= cmd.data;
        end else if (cmd.index == `LSI_G_DIR2) begin
          bidir2_direction <= cmd.data;
        end else if (cmd.index == `LSI_G_RING_TRIP) begin
          ring_trip_config <= {cmd.data[7:1], 1'b0};
        end else if (cmd.index == `LSI_G_CHOPPER) begin
          chopper_config <= cmd.data;
        end else if (cmd.index == `LSI_G_BIDIR1 && !gci_mode) begin
          bidir1_data_all <= cmd.data;
        end else if (cmd.index == `LSI_G_BIDIR2 && !gci_mode) begin
          bidir2_data_all <= cmd.data;
        end
      end
      if (ci_wr) begin
        bidir1_data_all[ci_down.channel] <= ci_down.data[`LSI_CI_B1];
        bidir2_data_all[ci_down.channel] <= ci_down.data[`LSI_CI_B2];
      end
    end
  end

  // Read answers, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      rsp <= '0;
    end else begin
      rsp.valid <= host_rd;
      rsp.data  <= 8'h00;
      if (host_rd & cmd.global_cmd) begin
        if (cmd.index == `LSI_G_DEB_HOOK) begin
          rsp.data <= debounced_hook_bit;
        end else if (cmd.index == `LSI_G_DEB_GKEY) begin
          rsp.data <= debounced_groundkey_bit;
        end else if (cmd.index == `LSI_G_BIDIR1) begin
          rsp.data <= (bidir_pin_one_in & ~bidir1_direction) | (bidir1_data_all & bidir1_direction);
        end else if (cmd.index == `LSI_G_BIDIR2) begin
          rsp.data <= (bidir_pin_two_in & ~bidir2_direction) | (bidir2_data_all & bidir2_direction);
        end else if (cmd.index == `LSI_G_DIR1) begin
          rsp.data <= bidir1_direction;
        end else if (cmd.index == `LSI_G_DIR2) begin
          rsp.data <= bidir2_direction;
        end else if (cmd.index == `LSI_G_RING_TRIP) begin
          rsp.data <= ring_trip_config;
        end else if (cmd.index == `LSI_G_CHOPPER) begin
          rsp.data <= chopper_config;
        end
      end else if (host_rd) begin
        if (cmd.index == `LSI_L_IRQ_EN) begin
          rsp.data <= {source_irq_enables[cmd.channel], 4'h0};
        end else if (cmd.index == `LSI_L_DEB_TIMES) begin
          rsp.data <= channel_debounce_times[cmd.channel];
        end else if (cmd.index == `LSI_L_SIGNAL) begin
          rsp.data <= {debounced_hook_bit[cmd.channel],
                       debounced_groundkey_bit[cmd.channel],
                       bidir_pin_one_in[cmd.channel] & ~bidir1_direction[cmd.channel],
                       bidir_pin_two_in[cmd.channel] & ~bidir2_direction[cmd.channel],
                       |pending[cmd.channel],
                       line_out_reg[cmd.channel]};
        end
      end
    end
  end

  // Per-channel logic
  for (genvar ch = 0; ch < 8; ch++) begin : g_ch
    logic [3:0] dsh_code;
    logic [3:0] gk_code;
    logic       hook_sample;
    logic [4:0] hook_cnt;
    logic [3:0] gk_timer;
    logic       gk_step;
    logic [2:0] gk_cnt;
    logic       hook_q;
    logic       gkey_q;
    logic       b1_q;
    logic       b2_q;
    logic [3:0] change;
    logic       trip_in;
    logic       offhook;
    logic       offhook_q;

    assign dsh_code = channel_debounce_times[ch][`LSI_DSH_LSB +: 4];
    assign gk_code  = channel_debounce_times[ch][`LSI_GK_LSB +: 4];
    // Code zero samples at the base 250 us rate
    assign gk_step  = (gk_code == 4'h0) ? sample_tick : (tick_gk & (gk_timer == gk_code - 4'h1));

    // Local configuration registers
    always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
        source_irq_enables[ch]     <= 4'h0;
        channel_debounce_times[ch] <= `LSI_RST_BYTE;
        line_out_reg[ch]           <= 3'h0;
      end else begin
        if (host_wr & ~cmd.global_cmd & cmd_ch_dec[ch]) begin
          if (cmd.index == `LSI_L_IRQ_EN) begin
            source_irq_enables[ch] <= cmd.data[`LSI_IE_LSB +: 4];
          end else if (cmd.index == `LSI_L_DEB_TIMES) begin
            channel_debounce_times[ch] <= cmd.data;
          end else if (cmd.index == `LSI_L_SIGNAL && !gci_mode) begin
            line_out_reg[ch] <= cmd.data[2:0];
          end
        end
        if (ci_wr & ci_ch_dec[ch]) begin
          line_out_reg[ch] <= ci_down.data[2:0];
        end
      end
    end

    // Switch-hook filter
    always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
        hook_sample            <= 1'b0;
        hook_cnt               <= 5'h00;
        debounced_hook_bit[ch] <= 1'b0;
      end else if (sample_tick) begin
        hook_sample <= hook_input[ch];
        if (hook_input[ch] != hook_sample) begin
          hook_cnt <= 5'h00;
        end else if (hook_cnt >= {dsh_code, 1'b0}) begin
          debounced_hook_bit[ch] <= hook_sample;
        end else if (tick_2ms) begin
          hook_cnt <= hook_cnt + 5'h01;
        end
      end else if (tick_2ms && hook_cnt < {dsh_code, 1'b0}) begin
        hook_cnt <= hook_cnt + 5'h01;
      end
    end

    // Ground-key filter
    always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
        gk_timer                    <= 4'h0;
        gk_cnt                      <= 3'h0;
        debounced_groundkey_bit[ch] <= 1'b0;
      end else begin
        if (tick_gk) begin
          gk_timer <= (gk_timer >= gk_code - 4'h1) ? 4'h0 : gk_timer + 4'h1;
        end
        if (gk_step) begin
          if (groundkey_input[ch] && gk_cnt != `LSI_GK_MAX) begin
            gk_cnt <= gk_cnt + 3'h1;
          end else if (!groundkey_input[ch] && gk_cnt != 3'h0) begin
            gk_cnt <= gk_cnt - 3'h1;
          end
        end
        if (gk_cnt == `LSI_GK_MAX) begin
          debounced_groundkey_bit[ch] <= 1'b1;
        end else if (gk_cnt == 3'h0) begin
          debounced_groundkey_bit[ch] <= 1'b0;
        end
      end
    end

    // Change detection; bidir pins are raw, so glitches reach software
    assign change = {b2_q ^ bidir_pin_two_in[ch], b1_q ^ bidir_pin_one_in[ch],
                     gkey_q ^ debounced_groundkey_bit[ch], hook_q ^ debounced_hook_bit[ch]};

    always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
        hook_q      <= 1'b0;
        gkey_q      <= 1'b0;
        b1_q        <= 1'b0;
        b2_q        <= 1'b0;
        pending[ch] <= 4'h0;
      end else begin
        hook_q <= debounced_hook_bit[ch];
        gkey_q <= debounced_groundkey_bit[ch];
        b1_q   <= bidir_pin_one_in[ch];
        b2_q   <= bidir_pin_two_in[ch];
        // Set wins over a clear in the same cycle
        pending[ch] <= ((irq_clear_all | local_sig_read[ch]) ? 4'h0 : pending[ch])
                       | (change & source_irq_enables[ch]
                          & {~bidir2_direction[ch], ~bidir1_direction[ch], 2'b11});
      end
    end

    // Hardware ring trip: forces ring output to idle until software rewrites it
    assign trip_in = trip_input_select ? debounced_groundkey_bit[ch] : debounced_hook_bit[ch];
    assign offhook = ~(trip_in ^ trip_input_polarity);

    always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
        offhook_q     <= 1'b0;
        trip_hold[ch] <= 1'b0;
      end else begin
        offhook_q <= offhook;
        if (ring_trip_enable & offhook & ~offhook_q) begin
          trip_hold[ch] <= 1'b1;
        end else if (sw_output_write[ch] | (host_wr & cmd.global_cmd &
                     ((cmd.index == `LSI_G_BIDIR1) | (cmd.index == `LSI_G_BIDIR2)))) begin
          trip_hold[ch] <= 1'b0;
        end
      end
    end

    // Registered pin drive
    always_ff @(posedge sys_clk or negedge rst_sync) begin
      if (!rst_sync) begin
        line_output_one[ch]   <= 1'b0;
        line_output_two[ch]   <= 1'b0;
        line_output_three[ch] <= 1'b0;
        bidir_pin_one_out[ch] <= 1'b0;
        bidir_pin_two_out[ch] <= 1'b0;
        bidir_pin_one_oe[ch]  <= 1'b0;
        bidir_pin_two_oe[ch]  <= 1'b0;
        ci_up[ch]             <= 8'h00;
        channel_irq[ch]       <= 1'b0;
      end else begin
        line_output_one[ch]   <= line_out_reg[ch][0];
        line_output_two[ch]   <= line_out_reg[ch][1];
        line_output_three[ch] <= line_out_reg[ch][2];
        bidir_pin_one_out[ch] <= bidir1_data_all[ch];
        bidir_pin_two_out[ch] <= bidir2_data_all[ch];
        bidir_pin_one_oe[ch]  <= bidir1_direction[ch];
        bidir_pin_two_oe[ch]  <= bidir2_direction[ch];
        if (trip_hold[ch] | (ring_trip_enable & offhook & ~offhook_q)) begin
          case (line_signaling_io_pkg::trip_out_e'(trip_output_select))
            line_signaling_io_pkg::TRIP_OUT_ONE:   line_output_one[ch]   <= ~trip_output_polarity;
            line_signaling_io_pkg::TRIP_OUT_TWO:   line_output_two[ch]   <= ~trip_output_polarity;
            line_signaling_io_pkg::TRIP_OUT_THREE: line_output_three[ch] <= ~trip_output_polarity;
            line_signaling_io_pkg::TRIP_BIDIR_ONE: begin
              if (bidir1_direction[ch]) begin
                bidir_pin_one_out[ch] <= ~trip_output_polarity;
              end
            end
            line_signaling_io_pkg::TRIP_BIDIR_TWO: begin
              if (bidir2_direction[ch]) begin
                bidir_pin_two_out[ch] <= ~trip_output_polarity;
              end
            end
            default: begin
            end
          endcase
        end
        ci_up[ch] <= {debounced_hook_bit[ch], debounced_groundkey_bit[ch],
                      bidir_pin_one_in[ch] & ~bidir1_direction[ch], 5'h00};
        channel_irq[ch] <= |pending[ch];
      end
    end
  end

  // Chopper clocks; fastest rate is limited to half the system clock
  logic [3:0] slow_ms;
  logic [3:0] slow_code;
  logic [5:0] fast_cnt;
  logic [5:0] fast_half;

  assign slow_code = (chopper_config[3:0] > `LSI_SLOW_MAX_CODE) ? `LSI_SLOW_MAX_CODE : chopper_config[3:0];
  assign fast_half = (chopper_config[`LSI_CHOP_FAST_LSB +: 2] == 2'h0) ? 6'(`LSI_HALF(`LSI_FAST0_HZ)) :
                     (chopper_config[`LSI_CHOP_FAST_LSB +: 2] == 2'h1) ? 6'(`LSI_HALF(`LSI_FAST1_HZ)) :
                     6'(`LSI_HALF(`LSI_FAST2_HZ));

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      slow_ms          <= 4'h0;
      slow_chopper_out <= 1'b0;
    end else if (tick_1ms) begin
      if (slow_ms >= slow_code) begin
        slow_ms          <= 4'h0;
        slow_chopper_out <= ~slow_chopper_out;
      end else begin
        slow_ms <= slow_ms + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      fast_cnt         <= 6'h00;
      fast_chopper_out <= 1'b0;
    end else if (fast_cnt >= fast_half - 6'h01) begin
      fast_cnt         <= 6'h00;
      fast_chopper_out <= ~fast_chopper_out;
    end else begin
      fast_cnt <= fast_cnt + 6'h01;
    end
  end

endmodule

`default_nettype wire

// *** sim/line_signaling_io_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_signaling_io_properties (
  input wire logic                                sys_clk, rst_n, gci_mode,
  input wire line_signaling_io_pkg::cmd_req_s     cmd,
  input wire line_signaling_io_pkg::cmd_rsp_s     rsp,
  input wire line_signaling_io_pkg::ci_octet_s    ci_down,
  input wire logic [7:0]                          bidir_pin_one_oe, line_output_one, line_output_two
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence rd_s; cmd.valid && !cmd.write; endsequence
  sequence lw_s; cmd.valid && cmd.write && !cmd.global_cmd && cmd.index == 5'h09; endsequence
  read_answer_a: assert property (rd_s |=> rsp.valid) else $error("read unanswered");
  no_stray_a: assert property (!(cmd.valid && !cmd.write) |=> !rsp.valid) else $error("stray answer");
  idle_data_a: assert property (!rsp.valid |-> rsp.data == 8'h00) else $error("data without valid");
  dir_read_a: assert property (rd_s ##0 cmd.global_cmd && cmd.index == 5'h0D
    |=> rsp.data == bidir_pin_one_oe) else $error("direction readback");
  dir_write_a: assert property (cmd.valid && cmd.write && cmd.global_cmd && cmd.index == 5'h0D
    |-> ##2 bidir_pin_one_oe == $past(cmd.data, 2)) else $error("direction write");
  host_out_a: assert property (lw_s ##0 !gci_mode
    |-> ##2 line_output_one[$past(cmd.channel, 2)] == $past(cmd.data[0], 2)) else $error("host output");
  ci_refuse_a: assert property (lw_s ##0 gci_mode
    |=> $stable(line_output_one) [*2]) else $error("host write taken");
  ci_write_a: assert property (gci_mode && ci_down.valid
    |-> ##2 line_output_two[$past(ci_down.channel, 2)] == $past(ci_down.data[1], 2)) else $error("octet output");
endmodule
bind line_signaling_io line_signaling_io_properties i_props (.*);
`default_nettype wire

// *** sim/slic_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module slic_model (
  input  wire logic [7:0] lvl, bidir_pin_one_out, bidir_pin_one_oe, bidir_pin_two_out, bidir_pin_two_oe,
  output logic [7:0]      bidir_pin_one_in, bidir_pin_two_in
);
  // Released pins show the line level, never an echo of the last drive
  assign bidir_pin_one_in = bidir_pin_one_oe & bidir_pin_one_out | ~bidir_pin_one_oe & lvl;
  assign bidir_pin_two_in = bidir_pin_two_oe & bidir_pin_two_out | ~bidir_pin_two_oe & lvl;
endmodule
`default_nettype wire

// *** sim/line_signaling_io_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module line_signaling_io_bench;
  logic       sys_clk = 0, rst_n = 0, gci_mode = 0, frame_sync = 0;
  logic [7:0] hook_input = 0, groundkey_input = 0, channel_irq, line_output_one, line_output_two;
  logic [7:0] line_output_three;
  logic [7:0][7:0] ci_up;
  logic slow_chopper_out, fast_chopper_out;
  logic [7:0] bidir_pin_one_in, bidir_pin_one_out, bidir_pin_one_oe;
  logic [7:0] bidir_pin_two_in, bidir_pin_two_out, bidir_pin_two_oe;
  line_signaling_io_pkg::cmd_req_s  cmd = '0;
  line_signaling_io_pkg::cmd_rsp_s  rsp;
  line_signaling_io_pkg::ci_octet_s ci_down = '0;
  int n_errors = 0, check_count = 0, cyc = 0;
  line_signaling_io i_dut (.*);
  slic_model i_slic (.*, .lvl(8'h3C));
  always #20 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    frame_sync <= cyc % 3125 == 0;
    if (cyc == 70000) end_of_test;
  end
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Waits for a toggle, then expects the next one exactly n cycles later
  task automatic half_period(input logic slow, input int n);
    logic w, same;
    w = slow ? slow_chopper_out : fast_chopper_out;
    while ((slow ? slow_chopper_out : fast_chopper_out) === w) @(negedge sys_clk);
    w = slow ? slow_chopper_out : fast_chopper_out;
    repeat (n - 1) @(negedge sys_clk);
    same = (slow ? slow_chopper_out : fast_chopper_out) === w;
    @(negedge sys_clk);
    chk({14'h0000, same, (slow ? slow_chopper_out : fast_chopper_out) === w}, 16'h0002);
  endtask
  task automatic xf(input logic w, g, input logic [4:0] ix, input logic [2:0] ch, input logic [7:0] d);
    @(negedge sys_clk);
    cmd = '{1'b1, w, g, ix, ch, d};
    @(negedge sys_clk);
    cmd.valid = 1'b0;
    if (!w) chk({7'h00, rsp.valid, rsp.data}, {8'h01, d});
  endtask
  task automatic end_of_test;
    if (cyc >= 70000) n_errors++;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1;
    repeat (3) @(negedge sys_clk);
    xf(0, 1, 5'h0D, 0, 8'h00);
    xf(1, 1, 5'h0D, 0, 8'hA5);
    xf(1, 1, 5'h0B, 0, 8'hFF);
    xf(0, 1, 5'h0B, 0, 8'hBD);
    xf(1, 0, 5'h09, 3, 8'h05);
    xf(0, 0, 5'h09, 3, 8'h35);
    gci_mode = 1;
    xf(1, 0, 5'h09, 3, 8'h00);
    xf(1, 1, 5'h0B, 0, 8'h00);
    ci_down = '{1'b1, 3'd2, 8'h02};
    @(negedge sys_clk);
    ci_down = '0;
    gci_mode = 0;
    repeat (2) @(negedge sys_clk);
    chk({bidir_pin_one_out, line_output_two}, 16'hFB04);
    chk({line_output_three, line_output_one}, 16'h0808);
    half_period(1'b0, 48);
    $display("pins done");
    xf(1, 0, 5'h02, 4, 8'h10);
    hook_input = 8'h50;
    groundkey_input = 8'h01;
    repeat (18750) @(negedge sys_clk);
    xf(0, 1, 5'h09, 0, 8'h50);
    chk({8'h00, ci_up[4]}, 16'h00A0);
    chk({8'h00, channel_irq}, 16'h0010);
    xf(0, 1, 5'h0A, 0, 8'h00);
    xf(0, 0, 5'h09, 4, 8'hB8);
    repeat (2) @(negedge sys_clk);
    chk({8'h00, channel_irq}, 16'h0000);
    $display("debounce done");
    xf(1, 0, 5'h09, 1, 8'h01);
    xf(1, 1, 5'h0F, 0, 8'h86);
    hook_input[1] = 1'b1;
    half_period(1'b1, 25000);
    chk({8'h00, line_output_one}, 16'h0008);
    xf(0, 0, 5'h09, 1, 8'h81);
    xf(0, 1, 5'h0A, 0, 8'h01);
    $display("ring trip done");
    end_of_test;
  end
endmodule
`default_nettype wire
